// >>> src/rsapc_pkg.sv
// shared constants for the rs-232 activity power control block
package rsapc_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned IDLE_OFF_DELAY_S = 30;
  localparam logic [63:0] IDLE_OFF_CYC_W = 64'(IDLE_OFF_DELAY_S) * 64'(CLK_HZ);
  localparam logic [31:0] IDLE_OFF_CYC = IDLE_OFF_CYC_W[31:0];
  localparam int unsigned WAKE_ON_DELAY_NS = 100_000;
  localparam int unsigned RAIL_SETTLE_NS = 50_000;
  localparam int unsigned VALID_FALL_DELAY_NS = 30_000;
  localparam int unsigned VALID_RISE_DELAY_NS = 400;

  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned WAKE_ON_CYC = ns_to_cyc(WAKE_ON_DELAY_NS);
  localparam int unsigned RAIL_SETTLE_CYC = ns_to_cyc(RAIL_SETTLE_NS);
  localparam int unsigned VALID_FALL_CYC = ns_to_cyc(VALID_FALL_DELAY_NS);
  localparam int unsigned VALID_RISE_CYC = ns_to_cyc(VALID_RISE_DELAY_NS);
  localparam int unsigned SHORT_CNT_W = 12;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL_OFS = 8'h00;
  localparam logic [7:0] REG_STATUS_OFS = 8'h04;
  localparam logic [7:0] REG_EVENT_OFS = 8'h08;
  localparam logic [7:0] REG_IDLE_OFS = 8'h0C;
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_VALID_BIT = 2;
  localparam int unsigned ST_READY_BIT = 3;
  localparam int unsigned ST_PUMP_BIT = 4;
  localparam int unsigned ST_FON_BIT = 5;
  localparam int unsigned ST_FOFFN_BIT = 6;
  localparam int unsigned EV_OFFLINE_BIT = 0;
  localparam int unsigned EV_FORCE_ON_SELECT_BIT = 1;
  localparam logic [1:0] EVENT_RST = 2'h0;

  // ----------------------------------------------------------------
  // power states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RSAPC_RUN = 2'b00,
    RSAPC_OFF = 2'b01,
    RSAPC_WAKE = 2'b11,
    RSAPC_FORCED = 2'b10
  } rsapc_state_e;

endpackage

// >>> src/rsapc_act_if.sv
// synchronised input levels and their edges
`timescale 1ns/1ps
`default_nettype none
interface rsapc_act_if #(parameter int W = 4);
  logic [W-1:0] level;
  logic [W-1:0] edge_det;
  modport src (output level, output edge_det);
  modport dst (input level, input edge_det);
endinterface
`default_nettype wire

// >>> src/rsapc_sync_edge.sv
// two-stage synchroniser with edge detection per bit
`timescale 1ns/1ps
`default_nettype none
module rsapc_sync_edge #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] async_in,
  rsapc_act_if.src act
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
      prev_q <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign act.level = sync_q;
  assign act.edge_det = sync_q ^ prev_q;
endmodule
`default_nettype wire

// >>> src/rsapc_top.sv
// activity-driven power control for an rs-232 transceiver
// Notes on behaviour
// (RULE1) auto mode: 30 s idle turns off
// (RULE2) any input edge wakes from idle off; the code wakes only on edges whose bit is set in the CTRL mask
// (RULE3) shutdown follows edges, not line levels
// (RULE4) force-on high keeps drivers active
// (RULE5) forced-off low overrides everything, drivers off
// (RULE6) valid indicator follows receiver level detection
// (RULE7) valid indicator never causes shutdown itself
// (RULE8) valid routed to force-on keeps device on
// (RULE9) valid routed to both pins gates power
// (RULE10) ready needs negative rail beyond threshold
// (RULE11) rails settle 50 us after wakeup
// (RULE12) valid falls 30 us, rises 0.4 us
// (RULE13) offline after 30 s, force_on_select 100 us
// (RULE14) receiver outputs stay active always
// (RULE15) idle timer restarts on edges, cleared outside auto mode run state
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module rsapc_top #(
  parameter int N = 2,
  parameter logic [31:0] IDLE_CYC = rsapc_pkg::IDLE_OFF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [N-1:0] drv_data_in,
  input wire logic [N-1:0] rx_line_in,
  input wire logic [N-1:0] rx_level_ok,
  input wire logic force_on_select,
  input wire logic forced_off_n,
  input wire logic neg_rail_ok,
  output logic [N-1:0] line_driver_outputs,
  output logic [N-1:0] line_driver_oe,
  output logic [N-1:0] rx_data_out,
  output logic pump_enable,
  output logic valid_ind,
  output logic ready
);
  import rsapc_pkg::*;

  localparam int unsigned RISE_LAST = VALID_RISE_CYC - 1;
  localparam int unsigned FALL_LAST = VALID_FALL_CYC - 1;
  localparam int unsigned WAKE_LAST = WAKE_ON_CYC - 1;

  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  rsapc_act_if #(.W(2 * N)) act_if ();
  rsapc_act_if #(.W(N + 3)) lvl_if ();

  rsapc_sync_edge #(.W(2 * N)) u_act_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({rx_line_in, drv_data_in}),
    .act(act_if.src)
  );

  rsapc_sync_edge #(.W(N + 3), .RST_VAL({3'h2, {N{1'b0}}})) u_lvl_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({neg_rail_ok, forced_off_n, force_on_select, rx_level_ok}),
    .act(lvl_if.src)
  );

  logic [2*N-1:0] mask_q;
  logic any_edge;
  logic lvl_any;
  logic fon_s;
  logic foffn_s;
  logic rail_s;
  logic auto_sel;

  assign any_edge = |(act_if.edge_det & mask_q); // see (RULE3)
  assign lvl_any = |lvl_if.level[N-1:0];
  assign fon_s = lvl_if.level[N];
  assign foffn_s = lvl_if.level[N+1];
  assign rail_s = lvl_if.level[N+2];
  assign auto_sel = foffn_s && !fon_s; // see (RULE4)

  // ----------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------
  rsapc_state_e state_q;
  rsapc_state_e state_d;
  logic [31:0] idle_cnt_q;
  logic [SHORT_CNT_W-1:0] wake_cnt_q;
  logic idle_done;
  logic wake_done;

  assign idle_done = (idle_cnt_q == IDLE_CYC - 32'h1) && !any_edge;
  assign wake_done = (wake_cnt_q == SHORT_CNT_W'(WAKE_LAST));

  always_comb begin
    state_d = state_q;
    if (!foffn_s) begin
      state_d = RSAPC_FORCED; // see (RULE5)
    end else begin
      case (state_q)
        RSAPC_RUN: begin
          if (auto_sel && idle_done) begin
            state_d = RSAPC_OFF; // see (RULE1)
          end
        end
        RSAPC_OFF: begin
          if (any_edge || fon_s) begin
            state_d = RSAPC_WAKE; // see (RULE2) see (RULE8)
          end
        end
        RSAPC_WAKE: begin
          if (wake_done) begin
            state_d = RSAPC_RUN; // see (RULE13)
          end
        end
        RSAPC_FORCED: state_d = RSAPC_WAKE; // see (RULE9)
        default: state_d = RSAPC_WAKE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= RSAPC_WAKE;
    end else begin
      state_q <= state_d;
    end
  end

  // idle timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt_q <= 32'h0;
    end else if (!auto_sel || state_q != RSAPC_RUN || any_edge) begin
      idle_cnt_q <= 32'h0; // see (RULE15)
    end else if (!idle_done) begin
      idle_cnt_q <= idle_cnt_q + 32'h1;
    end
  end

  // wake-to-force_on_select timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_cnt_q <= '0;
    end else if (state_q != RSAPC_WAKE) begin
      wake_cnt_q <= '0;
    end else if (!wake_done) begin
      wake_cnt_q <= wake_cnt_q + SHORT_CNT_W'(1); // see (RULE13)
    end
  end

  // ----------------------------------------------------------------
  // charge pump and ready
  // ----------------------------------------------------------------
  logic [SHORT_CNT_W-1:0] settle_cnt_q;
  logic settled;
  logic ready_q;

  assign pump_enable = (state_q == RSAPC_RUN) || (state_q == RSAPC_WAKE);
  assign settled = (settle_cnt_q == SHORT_CNT_W'(RAIL_SETTLE_CYC));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt_q <= '0;
    end else if (!pump_enable) begin
      settle_cnt_q <= '0;
    end else if (!settled) begin
      settle_cnt_q <= settle_cnt_q + SHORT_CNT_W'(1); // see (RULE11)
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= pump_enable && settled && rail_s; // see (RULE10)
    end
  end
  assign ready = ready_q;

  // ----------------------------------------------------------------
  // valid-signal indicator
  // ----------------------------------------------------------------
  logic valid_q;
  logic [SHORT_CNT_W-1:0] vcnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_q <= 1'b0;
      vcnt_q <= '0;
    end else if (lvl_any == valid_q) begin
      vcnt_q <= '0;
    end else if (!valid_q && vcnt_q == SHORT_CNT_W'(RISE_LAST)) begin
      valid_q <= 1'b1; // see (RULE6) see (RULE12)
      vcnt_q <= '0;
    end else if (valid_q && vcnt_q == SHORT_CNT_W'(FALL_LAST)) begin
      valid_q <= 1'b0; // see (RULE6) see (RULE12)
      vcnt_q <= '0;
    end else begin
      vcnt_q <= vcnt_q + SHORT_CNT_W'(1);
    end
  end
  assign valid_ind = valid_q; // see (RULE7)

  // ----------------------------------------------------------------
  // drivers and receivers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_driver_outputs <= '0;
      rx_data_out <= '0;
    end else begin
      line_driver_outputs <= ~act_if.level[N-1:0];
      rx_data_out <= act_if.level[2*N-1:N]; // see (RULE14)
    end
  end
  assign line_driver_oe = {N{state_q == RSAPC_RUN}};

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic [1:0] event_q;
  logic setup_ph;
  logic wr_acc;
  logic hit;
  logic went_off;
  logic came_on;

  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign pready = 1'b1;
  assign went_off = (state_q == RSAPC_RUN) && (state_d != RSAPC_RUN);
  assign came_on = (state_q != RSAPC_RUN) && (state_d == RSAPC_RUN);
  assign hit = (paddr == REG_CTRL_OFS) || (paddr == REG_STATUS_OFS) ||
               (paddr == REG_EVENT_OFS) || (paddr == REG_IDLE_OFS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= '1;
    end else if (wr_acc && paddr == REG_CTRL_OFS) begin
      mask_q <= pwdata[2*N-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_q <= EVENT_RST;
    end else begin
      if (wr_acc && paddr == REG_EVENT_OFS) begin
        event_q <= event_q & ~pwdata[1:0];
      end
      if (went_off) begin
        event_q[EV_OFFLINE_BIT] <= 1'b1;
      end
      if (came_on) begin
        event_q[EV_FORCE_ON_SELECT_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      pslverr <= !hit;
      prdata <= 32'h0;
      if (!pwrite) begin
        case (paddr)
          REG_CTRL_OFS: prdata <= 32'(mask_q);
          REG_STATUS_OFS: begin
            prdata[ST_STATE_LSB +: 2] <= state_q;
            prdata[ST_VALID_BIT] <= valid_q;
            prdata[ST_READY_BIT] <= ready_q;
            prdata[ST_PUMP_BIT] <= pump_enable;
            prdata[ST_FON_BIT] <= fon_s;
            prdata[ST_FOFFN_BIT] <= foffn_s;
          end
          REG_EVENT_OFS: prdata <= 32'(event_q);
          REG_IDLE_OFS: prdata <= idle_cnt_q;
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_idle_expire;
    state_q == RSAPC_RUN && auto_sel && idle_done;
  endsequence

  sequence s_off_edge;
    state_q == RSAPC_OFF && foffn_s && any_edge;
  endsequence

  chk_forced_off_hiz: assert property ( // see (RULE5)
    !foffn_s |=> (state_q == RSAPC_FORCED) && (line_driver_oe == '0) && !pump_enable)
    else $error("forced shutdown did not disable drivers");

  chk_idle_off_entry: assert property ( // see (RULE1)
    s_idle_expire |=> state_q == RSAPC_OFF && line_driver_oe == '0 && !pump_enable)
    else $error("idle timeout did not shut down");

  chk_edge_wakes: assert property ( // see (RULE2)
    s_off_edge |=> state_q == RSAPC_WAKE ##1 pump_enable)
    else $error("edge did not wake device");

  chk_level_no_wake: assert property ( // see (RULE3)
    state_q == RSAPC_OFF && foffn_s && !fon_s && !any_edge |=> state_q == RSAPC_OFF)
    else $error("left idle state without an edge");

  chk_force_on_hold: assert property ( // see (RULE4)
    state_q == RSAPC_RUN && fon_s && foffn_s |=> state_q == RSAPC_RUN)
    else $error("forced-on device left run state");

  chk_timer_clear: assert property ( // see (RULE15)
    !auto_sel || any_edge |=> idle_cnt_q == 32'h0)
    else $error("idle timer not cleared");

  chk_valid_rise: assert property ( // see (RULE12)
    $rose(valid_q) |-> $past(vcnt_q) == SHORT_CNT_W'(RISE_LAST) && $past(lvl_any))
    else $error("valid indicator rose at wrong time");

  chk_valid_fall: assert property ( // see (RULE6)
    $fell(valid_q) |-> $past(vcnt_q) == SHORT_CNT_W'(FALL_LAST) && !$past(lvl_any))
    else $error("valid indicator fell at wrong time");

  chk_ready_rail: assert property ( // see (RULE10)
    ready_q |-> $past(rail_s) && $past(pump_enable))
    else $error("ready without negative rail");

  chk_ready_settle: assert property ( // see (RULE11)
    $rose(ready_q) |-> $past(settle_cnt_q) == SHORT_CNT_W'(RAIL_SETTLE_CYC))
    else $error("ready before rail settle time");

  chk_force_on_select_delay: assert property ( // see (RULE13)
    state_q == RSAPC_WAKE && state_d == RSAPC_RUN |-> wake_cnt_q == SHORT_CNT_W'(WAKE_LAST))
    else $error("force_on_select before wake delay");

  chk_rx_follow: assert property ( // see (RULE14)
    rx_data_out == $past(act_if.level[2*N-1:N]))
    else $error("receiver output not following input");

endmodule
`default_nettype wire

// >>> tb/rsapc_far_model.sv
// far-side model: remote line driver and negative pump rail
`timescale 1ns/1ps
`default_nettype none
module rsapc_far_model #(
  parameter int RAIL_CYC = 1500
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pump_enable,
  input wire logic rail_fault,
  input wire logic cable_on,
  input wire logic send,
  output logic [1:0] rx_line_in,
  output logic [1:0] rx_level_ok,
  output logic neg_rail_ok
);
  int rail_cnt;
  logic [1:0] line_q;
  // ----------------------------------------------------------------
  // rail charges only while the pump runs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rail_cnt <= 0;
    end else if (!pump_enable) begin
      rail_cnt <= 0;
    end else if (rail_cnt < RAIL_CYC) begin
      rail_cnt <= rail_cnt + 1;
    end
  end
  assign neg_rail_ok = (rail_cnt >= RAIL_CYC) && !rail_fault;
  // ----------------------------------------------------------------
  // live cable toggles on request; unplugged lines rest at ground
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_q <= 2'h0;
    end else if (send) begin
      line_q <= ~line_q;
    end
  end
  assign rx_line_in = cable_on ? line_q : 2'h0;
  assign rx_level_ok = {2{cable_on}};
endmodule
`default_nettype wire

// >>> tb/rsapc_top_tb_top.sv
// testbench for the rs-232 activity power control block
`timescale 1ns/1ps
`default_nettype none
module rsapc_top_tb_top;
  import rsapc_pkg::*;
  localparam int IDLE = 200;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] drv_data_in, rx_line_in, rx_level_ok, line_driver_outputs;
  logic [1:0] line_driver_oe, rx_data_out;
  logic pump_enable, valid_ind, ready, neg_rail_ok, rail_fault, cable_on, send;
  logic fon_q, foff_q, route_on, route_off, fon, foff_n;
  int err_count, num_checks;

  // ----------------------------------------------------------------
  // host strapping of the valid indicator
  // ----------------------------------------------------------------
  assign fon = route_on ? valid_ind : fon_q;
  assign foff_n = route_off ? valid_ind : foff_q;

  rsapc_top #(.N(2), .IDLE_CYC(32'h000000C8)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .drv_data_in(drv_data_in),
    .rx_line_in(rx_line_in), .rx_level_ok(rx_level_ok),
    .force_on_select(fon), .forced_off_n(foff_n), .neg_rail_ok(neg_rail_ok),
    .line_driver_outputs(line_driver_outputs), .line_driver_oe(line_driver_oe),
    .rx_data_out(rx_data_out), .pump_enable(pump_enable),
    .valid_ind(valid_ind), .ready(ready)
  );

  rsapc_far_model #(.RAIL_CYC(1500)) far (
    .pclk(pclk), .presetn(presetn), .pump_enable(pump_enable),
    .rail_fault(rail_fault), .cable_on(cable_on), .send(send),
    .rx_line_in(rx_line_in), .rx_level_ok(rx_level_ok), .neg_rail_ok(neg_rail_ok)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdat, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic wait_oe(input logic [1:0] exp, input int lim);
    int n;
    n = 0;
    while (line_driver_oe !== exp && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk("oe_wait", {30'h0, exp}, {30'h0, line_driver_oe});
  endtask

  task automatic pulse();
    send <= 1'b1;
    @(posedge pclk);
    send <= 1'b0;
  endtask

  task automatic results();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial begin
    repeat (60000) @(posedge pclk);
    err_count++;
    $display("[ERR] watchdog expected end seen timeout");
    results();
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; drv_data_in = 2'h0; rail_fault = 1'b0;
    cable_on = 1'b1; send = 1'b0; fon_q = 1'b0; foff_q = 1'b1;
    route_on = 1'b0; route_off = 1'b0; err_count = 0; num_checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, REG_STATUS_OFS, 32'h0, rd, er);
    chk("state", 32'h3, {30'h0, rd[1:0]});
    apb(1'b0, REG_CTRL_OFS, 32'h0, rd, er);
    chk("ctrl", 32'h0000000F, rd);
    apb(1'b1, 8'h10, 32'h0, rd, er);
    chk("slverr", 32'h1, {31'h0, er});
    apb(1'b0, 8'h10, 32'h0, rd, er);
    chk("unmapped", 32'h0, rd);
    wait_oe(2'h3, 4200);
    chk("oe", 32'h3, {30'h0, line_driver_oe});
    chk("ready", 32'h1, {31'h0, ready});
    apb(1'b0, REG_EVENT_OFS, 32'h0, rd, er);
    chk("event", 32'h2, rd);
    apb(1'b1, REG_EVENT_OFS, 32'h2, rd, er);
    apb(1'b0, REG_EVENT_OFS, 32'h0, rd, er);
    chk("event", 32'h0, rd);
    drv_data_in <= 2'b01;
    cyc(5);
    chk("drv", 32'h2, {30'h0, line_driver_outputs});
    cyc(IDLE - 30);
    pulse();
    cyc(IDLE - 30);
    chk("oe", 32'h3, {30'h0, line_driver_oe});
    cyc(60);
    chk("oe", 32'h0, {30'h0, line_driver_oe});
    chk("pump", 32'h0, {31'h0, pump_enable});
    chk("valid", 32'h1, {31'h0, valid_ind});
    apb(1'b0, REG_STATUS_OFS, 32'h0, rd, er);
    chk("state", 32'h1, {30'h0, rd[1:0]});
    apb(1'b0, REG_EVENT_OFS, 32'h0, rd, er);
    chk("event", 32'h1, rd);
    apb(1'b1, REG_CTRL_OFS, 32'h0000000E, rd, er);
    apb(1'b0, REG_CTRL_OFS, 32'h0, rd, er);
    chk("ctrl", 32'h0000000E, rd);
    drv_data_in <= 2'b00;
    cyc(8);
    chk("pump", 32'h0, {31'h0, pump_enable});
    apb(1'b1, REG_CTRL_OFS, 32'h0000000F, rd, er);
    pulse();
    cyc(6);
    chk("pump", 32'h1, {31'h0, pump_enable});
    chk("rx", {30'h0, rx_line_in}, {30'h0, rx_data_out});
    wait_oe(2'h3, 4100);
    chk("oe", 32'h3, {30'h0, line_driver_oe});
    fon_q <= 1'b1;
    cyc(IDLE + 100);
    chk("oe", 32'h3, {30'h0, line_driver_oe});
    apb(1'b0, REG_IDLE_OFS, 32'h0, rd, er);
    chk("idle", 32'h0, rd);
    foff_q <= 1'b0;
    cyc(5);
    pulse();
    cyc(6);
    chk("oe", 32'h0, {30'h0, line_driver_oe});
    chk("pump", 32'h0, {31'h0, pump_enable});
    chk("rx", {30'h0, rx_line_in}, {30'h0, rx_data_out});
    foff_q <= 1'b1;
    wait_oe(2'h3, 4100);
    rail_fault <= 1'b1;
    cyc(5);
    chk("ready", 32'h0, {31'h0, ready});
    rail_fault <= 1'b0;
    cable_on <= 1'b0;
    cyc(1000);
    chk("valid", 32'h1, {31'h0, valid_ind});
    cyc(250);
    chk("valid", 32'h0, {31'h0, valid_ind});
    cable_on <= 1'b1;
    cyc(10);
    chk("valid", 32'h0, {31'h0, valid_ind});
    cyc(15);
    chk("valid", 32'h1, {31'h0, valid_ind});
    route_on <= 1'b1;
    cyc(IDLE + 100);
    chk("oe", 32'h3, {30'h0, line_driver_oe});
    cable_on <= 1'b0;
    cyc(1300);
    chk("oe", 32'h3, {30'h0, line_driver_oe});
    cyc(200);
    chk("oe", 32'h0, {30'h0, line_driver_oe});
    cable_on <= 1'b1;
    cyc(30);
    chk("pump", 32'h1, {31'h0, pump_enable});
    wait_oe(2'h3, 4100);
    route_off <= 1'b1;
    cable_on <= 1'b0;
    cyc(1300);
    chk("oe", 32'h0, {30'h0, line_driver_oe});
    chk("pump", 32'h0, {31'h0, pump_enable});
    cable_on <= 1'b1;
    cyc(30);
    chk("pump", 32'h1, {31'h0, pump_enable});
    wait_oe(2'h3, 4100);
    chk("oe", 32'h3, {30'h0, line_driver_oe});
    results();
  end
endmodule
`default_nettype wire
